/* File: drs_pkg.sv */
// Package of the digital reference selector: codes, widths, limits.
// Assumes a single 200 MHz clock and no register bus.
package drs_pkg;
   // ==========================================================
   // Widths and counts
   localparam int REF_W = 16;
   localparam int NUM_BIN = 6;
   localparam int NUM_CW = 11;
   localparam int NUM_REF = 17;
   localparam int IDX_W = 5;
   localparam int CODE_W = 5;
   // ==========================================================
   // Function codes
   localparam logic [CODE_W-1:0] FC_JOG = 5'h0D;
   localparam logic [CODE_W-1:0] FC_JOG_BYP = 5'h0E;
   localparam logic [CODE_W-1:0] FC_THR = 5'h0F;
   localparam logic [CODE_W-1:0] FC_THR_BYP = 5'h10;
   localparam logic [CODE_W-1:0] FC_FIX = 5'h11;
   localparam logic [CODE_W-1:0] FC_FIX_BYP = 5'h12;
   localparam logic [CODE_W-1:0] FC_OPT_TECH = 5'h13;
   localparam logic [CODE_W-1:0] FC_OPT_RAMP = 5'h14;
   localparam logic [CODE_W-1:0] FC_OPT_SPD = 5'h15;
   localparam logic [CODE_W-1:0] FC_OPT_TRQ = 5'h16;
   localparam logic [CODE_W-1:0] FC_OPT_CUR = 5'h17;
   // ==========================================================
   // Reference limits in units of 0.01 percent
   localparam logic signed [REF_W-1:0] REF_MIN = 16'hB1EA;
   localparam logic signed [REF_W-1:0] REF_MAX = 16'h4E1F;
   localparam logic signed [REF_W-1:0] REF_RESET = 16'h0000;
   // ==========================================================
   // Slot index of the first control-word reference
   localparam logic [IDX_W-1:0] CW_BASE = 5'h06;
   // ==========================================================
   // Injection points
   typedef enum logic [2:0] {
      INJ_NONE, INJ_TECH, INJ_RAMP, INJ_SPD, INJ_TRQ, INJ_CUR
   } drs_inj_t;
endpackage

/* File: drs_ref_mem.sv */
// Holds the eleven-plus-six stored references with a registered read.
// Assumes writes arrive already limited and on the system clock.
`timescale 1ns/1ps
module drs_ref_mem (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // Write port
   input wire logic wr_en,
   input wire logic [drs_pkg::IDX_W-1:0] wr_idx,
   input wire logic signed [drs_pkg::REF_W-1:0] wr_data,
   // Read port
   input wire logic [drs_pkg::IDX_W-1:0] rd_idx,
   output logic signed [drs_pkg::REF_W-1:0] rd_data
);
   import drs_pkg::*;
   typedef struct packed {
      logic [NUM_REF-1:0][REF_W-1:0] mem;
      logic [REF_W-1:0] rd;
   } drs_mem_t;
   drs_mem_t st_ff;
   drs_mem_t nxt_st;
   always_comb begin
      nxt_st = st_ff;
      if (wr_en && (wr_idx < IDX_W'(NUM_REF))) begin
         nxt_st.mem[wr_idx] = wr_data;
      end
      if (rd_idx < IDX_W'(NUM_REF)) begin
         nxt_st.rd = st_ff.mem[rd_idx];
      end else begin
         nxt_st.rd = REF_RESET;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign rd_data = st_ff.rd;
endmodule

/* File: drs_top.sv */
// Digital reference selector: picks a stored reference from requests.
// Assumes binary inputs come from pins, control word from same clock.
`timescale 1ns/1ps
module drs_top (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // Binary input terminals and their function codes
   input wire logic [drs_pkg::NUM_BIN-1:0] BIN_IN,
   input wire logic [drs_pkg::CODE_W-1:0] BIN_FUNC_CODE_1,
   input wire logic [drs_pkg::CODE_W-1:0] BIN_FUNC_CODE_2,
   input wire logic [drs_pkg::CODE_W-1:0] BIN_FUNC_CODE_3,
   input wire logic [drs_pkg::CODE_W-1:0] BIN_FUNC_CODE_4,
   input wire logic [drs_pkg::CODE_W-1:0] BIN_FUNC_CODE_5,
   input wire logic [drs_pkg::CODE_W-1:0] BIN_FUNC_CODE_6,
   // Free control word requests, bit k is code 13 plus k
   input wire logic [drs_pkg::NUM_CW-1:0] FREE_CONTROL_WORD,
   // Reference write port
   input wire logic REF_WR_EN,
   input wire logic [drs_pkg::IDX_W-1:0] REF_WR_IDX,
   input wire logic signed [drs_pkg::REF_W-1:0] REF_WR_DATA,
   // Main reference
   input wire logic signed [drs_pkg::REF_W-1:0] MAIN_REF,
   // Selected reference and routing
   output logic signed [drs_pkg::REF_W-1:0] ACTIVE_REF,
   output logic REF_SELECTED,
   output logic RAMP_BYPASS,
   output logic [2:0] INJECT_POINT,
   output logic [drs_pkg::IDX_W-1:0] ACTIVE_IDX
);
   import drs_pkg::*;

   // ==========================================================
   // Decoding of function codes
   function automatic logic is_select_code(input logic [CODE_W-1:0] c);
      return (c >= FC_JOG) && (c <= FC_OPT_CUR);
   endfunction

   function automatic logic is_bypass_code(input logic [CODE_W-1:0] c);
      return (c == FC_JOG_BYP) || (c == FC_THR_BYP) || (c == FC_FIX_BYP);
   endfunction

   function automatic drs_inj_t inj_of(input logic [CODE_W-1:0] c);
      case (c)
         FC_OPT_TECH: return INJ_TECH;
         FC_OPT_RAMP: return INJ_RAMP;
         FC_OPT_SPD: return INJ_SPD;
         FC_OPT_TRQ: return INJ_TRQ;
         FC_OPT_CUR: return INJ_CUR;
         default: return INJ_NONE;
      endcase
   endfunction

   function automatic logic signed [REF_W-1:0] clamp_ref(
      input logic signed [REF_W-1:0] v);
      if (v < REF_MIN) begin
         return REF_MIN;
      end else if (v > REF_MAX) begin
         return REF_MAX;
      end else begin
         return v;
      end
   endfunction

   // ==========================================================
   // State
   typedef struct packed {
      logic [NUM_BIN-1:0] sync1;
      logic [NUM_BIN-1:0] sync2;
      logic sel;
      logic byp;
      drs_inj_t inj;
      logic [IDX_W-1:0] idx;
      logic [REF_W-1:0] main_d;
      logic signed [REF_W-1:0] out;
   } drs_state_t;

   drs_state_t st_ff;
   drs_state_t nxt_st;

   logic [NUM_BIN-1:0][CODE_W-1:0] bin_code;
   logic [NUM_BIN-1:0] bin_req;
   logic [CODE_W-1:0] cw_code [NUM_CW];
   logic signed [REF_W-1:0] mem_rd;
   logic [IDX_W-1:0] sel_idx;
   logic sel_any;
   logic sel_byp;
   drs_inj_t sel_inj;

   assign bin_code[0] = BIN_FUNC_CODE_1;
   assign bin_code[1] = BIN_FUNC_CODE_2;
   assign bin_code[2] = BIN_FUNC_CODE_3;
   assign bin_code[3] = BIN_FUNC_CODE_4;
   assign bin_code[4] = BIN_FUNC_CODE_5;
   assign bin_code[5] = BIN_FUNC_CODE_6;

   // ==========================================================
   // Binary input requests
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BIN; gi++) begin : g_bin
         assign bin_req[gi] = st_ff.sync2[gi] &&
            is_select_code(bin_code[gi]);
      end
      for (gi = 0; gi < NUM_CW; gi++) begin : g_cw
         assign cw_code[gi] = FC_JOG + CODE_W'(gi);
      end
   endgenerate

   // ==========================================================
   // Priority selection
   always_comb begin
      sel_any = 1'b0;
      sel_idx = '0;
      sel_byp = 1'b0;
      sel_inj = INJ_NONE;
      for (int k = NUM_CW - 1; k >= 0; k--) begin
         if (FREE_CONTROL_WORD[k]) begin
            sel_any = 1'b1;
            sel_idx = CW_BASE + IDX_W'(k);
            sel_byp = is_bypass_code(cw_code[k]);
            sel_inj = inj_of(cw_code[k]);
         end
      end
      for (int k = NUM_BIN - 1; k >= 0; k--) begin
         if (bin_req[k]) begin
            sel_any = 1'b1;
            sel_idx = IDX_W'(k);
            sel_byp = is_bypass_code(bin_code[k]);
            sel_inj = inj_of(bin_code[k]);
         end
      end
   end

   // ==========================================================
   // Stored references
   drs_ref_mem u_mem (
      .SYS_CLK(SYS_CLK),
      .RST_N(RST_N),
      .wr_en(REF_WR_EN),
      .wr_idx(REF_WR_IDX),
      .wr_data(clamp_ref(REF_WR_DATA)),
      .rd_idx(sel_idx),
      .rd_data(mem_rd)
   );

   // ==========================================================
   // Pipeline aligned to the registered memory read
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sync1 = BIN_IN;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.sel = sel_any;
      nxt_st.byp = sel_byp;
      nxt_st.inj = sel_inj;
      nxt_st.idx = sel_idx;
      nxt_st.main_d = MAIN_REF;
      if (st_ff.sel) begin
         nxt_st.out = mem_rd;
      end else begin
         nxt_st.out = st_ff.main_d;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign ACTIVE_REF = st_ff.out;
   assign REF_SELECTED = st_ff.sel;
   assign RAMP_BYPASS = st_ff.byp;
   assign INJECT_POINT = st_ff.inj;
   assign ACTIVE_IDX = st_ff.idx;
endmodule

/* File: drs_chk.sv */
// Assertions on the selector outputs.
// Assumes it is bound to drs_top.
`timescale 1ns/1ps
module drs_chk (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // Requests
   input wire logic [drs_pkg::NUM_BIN-1:0] BIN_IN,
   input wire logic [drs_pkg::CODE_W-1:0] BIN_FUNC_CODE_1,
   input wire logic [drs_pkg::NUM_CW-1:0] FREE_CONTROL_WORD,
   input wire logic signed [drs_pkg::REF_W-1:0] MAIN_REF,
   // Selection
   input wire logic signed [drs_pkg::REF_W-1:0] ACTIVE_REF,
   input wire logic REF_SELECTED,
   input wire logic RAMP_BYPASS,
   input wire logic [2:0] INJECT_POINT,
   input wire logic [drs_pkg::IDX_W-1:0] ACTIVE_IDX
);
   import drs_pkg::*;
   logic [IDX_W-1:0] cw_idx;
   // ====
   // Slot of the winning control word bit.
   always_comb begin
      cw_idx = 5'h00;
      for (int k = 10; k >= 0; k--)
         if (FREE_CONTROL_WORD[k]) cw_idx = 5'(k + 6);
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   sequence cw_req;
      (BIN_IN == 6'h00)[*4] ##0 (|FREE_CONTROL_WORD);
   endsequence
   a_cw_slot: assert property (cw_req
      |=> REF_SELECTED && ACTIVE_IDX == $past(cw_idx)) else $error("slot");
   a_cw_bypass: assert property (cw_req
      |=> RAMP_BYPASS == ($past(cw_idx) inside {5'h07, 5'h09, 5'h0B}))
      else $error("bypass");
   a_cw_inject: assert property (cw_req
      |=> INJECT_POINT == ($past(cw_idx) > 5'h0B ?
      3'($past(cw_idx) - 5'h0B) : 3'h0)) else $error("inject");
   a_bin1_wins: assert property (
      (BIN_IN[0] && BIN_FUNC_CODE_1 inside {[5'h0D:5'h17]})[*4]
      |=> REF_SELECTED && ACTIVE_IDX == 5'h00) else $error("input one");
   a_idle_off: assert property (
      (BIN_IN == 6'h00 && FREE_CONTROL_WORD == 11'h000)[*4]
      |=> !REF_SELECTED) else $error("idle select");
   a_idle_main: assert property (
      !REF_SELECTED && $past(RST_N) |=> ACTIVE_REF == $past(MAIN_REF, 2))
      else $error("main ref");
   a_idle_route: assert property (
      !REF_SELECTED |-> !RAMP_BYPASS && INJECT_POINT == 3'h0)
      else $error("idle route");
   a_reset_clear: assert property (
      $rose(RST_N) |-> ACTIVE_REF == 16'h0000 && !REF_SELECTED)
      else $error("reset value");
endmodule
bind drs_top drs_chk chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .BIN_IN(BIN_IN),
   .BIN_FUNC_CODE_1(BIN_FUNC_CODE_1), .FREE_CONTROL_WORD(FREE_CONTROL_WORD),
   .MAIN_REF(MAIN_REF), .ACTIVE_REF(ACTIVE_REF), .REF_SELECTED(REF_SELECTED),
   .RAMP_BYPASS(RAMP_BYPASS), .INJECT_POINT(INJECT_POINT),
   .ACTIVE_IDX(ACTIVE_IDX));

/* File: drs_req_src.sv */
// Terminal and control word source.
// Assumes the bench hands it requests.
`timescale 1ns/1ps
module drs_req_src (
   // Clock
   input wire logic clk,
   // Requests
   input wire logic [5:0] bin_req,
   input wire logic [10:0] cw_req,
   // Terminals
   output logic [5:0] bin_out = 6'h00,
   output logic [10:0] cw_out = 11'h000
);
   // ====
   // Terminals change off the sampling edge.
   always @(negedge clk) begin
      bin_out <= bin_req;
      cw_out <= cw_req;
   end
endmodule

/* File: testbench.sv */
// Self-checking bench for the selector.
// Assumes the design and checker files.
`timescale 1ns/1ps
module testbench;
   import drs_pkg::*;
   logic SYS_CLK = 1'b0, RST_N = 1'b0, wr_en = 1'b0, sel, byp;
   logic [5:0] bin_req = 6'h00, bin_in;
   logic [10:0] cw_req = 11'h000, cw;
   logic [4:0] fc [6] = '{default: 5'h00};
   logic [4:0] wr_idx = 5'h00, idx;
   logic signed [15:0] wr_data = 16'h0000, main_ref = 16'h0000, act;
   logic [2:0] inj;
   int refs [17] = '{default: 0};
   int n_fail = 0, compares = 0;
   always #2.5 SYS_CLK = ~SYS_CLK;
   drs_req_src src_u (.clk(SYS_CLK), .bin_req(bin_req), .cw_req(cw_req),
      .bin_out(bin_in), .cw_out(cw));
   drs_top dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .BIN_IN(bin_in),
      .BIN_FUNC_CODE_1(fc[0]), .BIN_FUNC_CODE_2(fc[1]),
      .BIN_FUNC_CODE_3(fc[2]), .BIN_FUNC_CODE_4(fc[3]),
      .BIN_FUNC_CODE_5(fc[4]), .BIN_FUNC_CODE_6(fc[5]),
      .FREE_CONTROL_WORD(cw), .REF_WR_EN(wr_en), .REF_WR_IDX(wr_idx),
      .REF_WR_DATA(wr_data), .MAIN_REF(main_ref), .ACTIVE_REF(act),
      .REF_SELECTED(sel), .RAMP_BYPASS(byp), .INJECT_POINT(inj),
      .ACTIVE_IDX(idx));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input int i, input int v);
      @(negedge SYS_CLK);
      wr_en = 1'b1;
      wr_idx = 5'(i);
      wr_data = 16'(v);
      @(negedge SYS_CLK);
      wr_en = 1'b0;
      if (i < 17) refs[i] = v < -19990 ? -19990 : (v > 19999 ? 19999 : v);
   endtask
   task automatic req(input logic [5:0] b, input logic [10:0] c);
      int w = -1;
      int f = 0;
      @(negedge SYS_CLK);
      bin_req <= b;
      cw_req <= c;
      for (int k = 16; k >= 0; k--)
         if (k < 6 ? b[k] && fc[k] inside {[13:23]} : c[k-6]) begin
            w = k;
            f = k < 6 ? int'(fc[k]) : k + 7;
         end
      repeat (6) @(posedge SYS_CLK);
      #1;
      chk(16'(sel), 16'(w >= 0));
      chk(act, w < 0 ? main_ref : 16'(refs[w]));
      chk(16'(byp), 16'(f inside {14, 16, 18}));
      chk(16'(inj), 16'(f > 18 ? f - 18 : 0));
      if (w >= 0) chk(16'(idx), 16'(w));
   endtask
   initial begin
      void'($urandom(79934));
      repeat (16) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      RST_N = 1'b1;
      chk(act, 16'h0000);
      for (int k = 0; k < 11; k++) req(6'h00, 11'(1 << k));
      $display("test defaults done");
      for (int i = 0; i < 18; i++) wr(i, $urandom_range(60000) - 30000);
      for (int i = 0; i < 6; i++) begin
         @(negedge SYS_CLK);
         fc[i] = 5'(13 + $urandom_range(10));
         req(6'(1 << i), 11'h7FF);
      end
      for (int k = 0; k < 11; k++) req(6'h00, 11'(1 << k));
      wr(7, 12345);
      req(6'h00, 11'h002);
      wr(6, -20000);
      wr(8, 20000);
      req(6'h00, 11'h001);
      req(6'h00, 11'h004);
      $display("test stored done");
      repeat (30) begin
         @(negedge SYS_CLK);
         fc[$urandom_range(5)] = 5'($urandom);
         main_ref = 16'($urandom);
         req(6'($urandom), 11'($urandom));
      end
      req(6'h00, 11'h000);
      $display("test priority done");
      req(6'h00, 11'h7FF);
      @(negedge SYS_CLK);
      RST_N = 1'b0;
      repeat (16) @(negedge SYS_CLK);
      RST_N = 1'b1;
      refs = '{default: 0};
      chk(act, 16'h0000);
      chk(16'(sel), 16'h0000);
      for (int k = 0; k < 11; k++) req(6'h00, 11'(1 << k));
      $display("test reset done");
      conclude();
   end
endmodule
